/* verilog/trigger_sequencer.sv */
// trigger sequencer with serial frame matcher, registers over AXI4-Lite
// assumes line inputs and ext_event synchronous to aclk
// Operation
// - frame matcher watches one selected channel
// - bit rate 110 to 2M via divider
// - five to eight data bits per frame
// - even, odd or no parity; 1/2 stops
// - start edge follows idle polarity setting
// - four patterns, first match alone fires
// - pattern up to sixteen consecutive characters
// - true condition goes to configured true target
// - false condition branches to configured target
// - self link holds state while false
// - trigger-linked true state asserts capture trigger
// - eight events joined by OR or AND
// - group of four states, two counters
// - two timers, 48-bit sample-clock resolution
// - true state resets counters, restarts timers
// - timer qualifier at-least, below, between
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module trigger_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] line_in,
  input wire logic ext_event,
  output logic trigger_out
);
  // ==========================================================
  // register bus
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next, wr_fire;
  logic [11:0] wa_reg, wa_next;
  logic [31:0] wd_reg, wd_next, rdata_next;
  logic [3:0] ws_reg, ws_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [8:0] ctrl_reg, ctrl_next;
  logic [17:0] baud_reg, baud_next;
  logic [19:0] plen_reg, plen_next;
  logic [31:0] c1lim_reg, c1lim_next, c2lim_reg, c2lim_next;
  logic [47:0] t1lim_reg, t1lim_next, t2lim_reg, t2lim_next;
  logic [21:0] scfg_reg [4];
  logic [21:0] scfg_next [4];
  logic [7:0] pat_reg [64];
  logic [7:0] pat_next [64];
  logic [31:0] bm, stat;
  logic [1:0] cur_reg, cur_next;
  logic trig_reg, trig_next;
  logic [3:0] hit_reg, hit_next;
  logic [7:0] char_reg, char_next;
  logic perr_reg, perr_next, ferr_reg, ferr_next;

  function automatic logic mapped(input logic [11:0] a);
    mapped = a[1:0] == 2'h0 && (a <= tsq_pkg::T2HI_OFS
      || a[11:4] == tsq_pkg::SCFG_PAGE || a[11:8] == tsq_pkg::PAT_PAGE);
  endfunction

  function automatic logic [31:0] rd_word(input logic [11:0] a);
    rd_word = 32'h0;
    if (a[11:8] == tsq_pkg::PAT_PAGE) rd_word = {24'h0, pat_reg[a[7:2]]};
    else if (a[11:4] == tsq_pkg::SCFG_PAGE) rd_word = {10'h0, scfg_reg[a[3:2]]};
    else case (a)
      tsq_pkg::CTRL_OFS: rd_word = {23'h0, ctrl_reg};
      tsq_pkg::BAUD_OFS: rd_word = {14'h0, baud_reg};
      tsq_pkg::STAT_OFS: rd_word = stat;
      tsq_pkg::PLEN_OFS: rd_word = {12'h0, plen_reg};
      tsq_pkg::C1LIM_OFS: rd_word = c1lim_reg;
      tsq_pkg::C2LIM_OFS: rd_word = c2lim_reg;
      tsq_pkg::T1LO_OFS: rd_word = t1lim_reg[31:0];
      tsq_pkg::T1HI_OFS: rd_word = {16'h0, t1lim_reg[47:32]};
      tsq_pkg::T2LO_OFS: rd_word = t2lim_reg[31:0];
      tsq_pkg::T2HI_OFS: rd_word = {16'h0, t2lim_reg[47:32]};
      default: rd_word = 32'h0;
    endcase
  endfunction

  always_comb begin
    stat = {14'h0, ferr_reg, perr_reg, char_reg, 1'b0, hit_reg, trig_reg, cur_reg};
    wr_fire = aw_have_reg & w_have_reg & ~bvalid;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    wa_next = wa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bvalid_next = bvalid;
    bresp_next = bresp;
    rvalid_next = rvalid;
    rresp_next = rresp;
    rdata_next = rdata;
    if (awvalid && awready) begin
      aw_have_next = 1'b1;
      wa_next = awaddr;
    end
    if (wvalid && wready) begin
      w_have_next = 1'b1;
      wd_next = wdata;
      ws_next = wstrb;
    end
    if (bvalid && bready) bvalid_next = 1'b0;
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped(wa_reg) ? tsq_pkg::RESP_OK : tsq_pkg::RESP_ERR;
    end
    if (rvalid && rready) rvalid_next = 1'b0;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word(araddr);
      rresp_next = mapped(araddr) ? tsq_pkg::RESP_OK : tsq_pkg::RESP_ERR;
    end
    awready_next = ~aw_have_next;
    wready_next = ~w_have_next;
    arready_next = ~rvalid_next;
    // byte-lane merge of the pending write into the addressed word
    bm = rd_word(wa_reg);
    for (int i = 0; i < 4; i++) if (ws_reg[i]) bm[8*i +: 8] = wd_reg[8*i +: 8];
    ctrl_next = ctrl_reg;
    baud_next = baud_reg;
    plen_next = plen_reg;
    c1lim_next = c1lim_reg;
    c2lim_next = c2lim_reg;
    t1lim_next = t1lim_reg;
    t2lim_next = t2lim_reg;
    scfg_next = scfg_reg;
    pat_next = pat_reg;
    // misaligned or unmapped writes answer with an error and change nothing
    if (wr_fire && mapped(wa_reg)) begin
      if (wa_reg[11:8] == tsq_pkg::PAT_PAGE) pat_next[wa_reg[7:2]] = bm[7:0];
      else if (wa_reg[11:4] == tsq_pkg::SCFG_PAGE) scfg_next[wa_reg[3:2]] = bm[21:0];
      else case (wa_reg)
        tsq_pkg::CTRL_OFS: ctrl_next = bm[8:0];
        tsq_pkg::BAUD_OFS: baud_next = bm[17:0];
        tsq_pkg::PLEN_OFS: plen_next = bm[19:0];
        tsq_pkg::C1LIM_OFS: c1lim_next = bm;
        tsq_pkg::C2LIM_OFS: c2lim_next = bm;
        tsq_pkg::T1LO_OFS: t1lim_next[31:0] = bm;
        tsq_pkg::T1HI_OFS: t1lim_next[47:32] = bm[15:0];
        tsq_pkg::T2LO_OFS: t2lim_next[31:0] = bm;
        tsq_pkg::T2HI_OFS: t2lim_next[47:32] = bm[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_have_reg, w_have_reg, bvalid, rvalid} <= 4'h0;
      {awready, wready, arready} <= 3'h7;
      wa_reg <= 12'h000;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      bresp <= 2'h0;
      rresp <= 2'h0;
      rdata <= 32'h0;
      ctrl_reg <= 9'h000;
      baud_reg <= tsq_pkg::DIV_RST;
      plen_reg <= 20'h0;
      c1lim_reg <= 32'h0;
      c2lim_reg <= 32'h0;
      t1lim_reg <= 48'h0;
      t2lim_reg <= 48'h0;
      for (int i = 0; i < 4; i++) scfg_reg[i] <= 22'h0;
      for (int i = 0; i < 64; i++) pat_reg[i] <= 8'h00;
    end else begin
      {aw_have_reg, w_have_reg, bvalid, rvalid} <=
        {aw_have_next, w_have_next, bvalid_next, rvalid_next};
      {awready, wready, arready} <= {awready_next, wready_next, arready_next};
      wa_reg <= wa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bresp <= bresp_next;
      rresp <= rresp_next;
      rdata <= rdata_next;
      ctrl_reg <= ctrl_next;
      baud_reg <= baud_next;
      plen_reg <= plen_next;
      c1lim_reg <= c1lim_next;
      c2lim_reg <= c2lim_next;
      t1lim_reg <= t1lim_next;
      t2lim_reg <= t2lim_next;
      scfg_reg <= scfg_next;
      pat_reg <= pat_next;
    end
  end

  // ==========================================================
  // serial frame receiver
  tsq_pkg::rx_state_t rx_state_reg, rx_state_next;
  logic [17:0] bcnt_reg, bcnt_next;
  logic [2:0] nbit_reg, nbit_next, last_bit;
  logic [7:0] sh_reg, sh_next;
  logic par_reg, par_next, prev_reg, stop2_reg, stop2_next, stb_reg, stb_next;
  logic line, tick, stop_done;
  logic [1:0] pmode;

  always_comb begin
    line = line_in[ctrl_reg[tsq_pkg::CH_LSB +: 2]]
      ^ ctrl_reg[tsq_pkg::IDLE_LO_BIT];
    pmode = ctrl_reg[tsq_pkg::PAR_LSB +: 2];
    last_bit = 3'h4 + {1'b0, ctrl_reg[tsq_pkg::DB_LSB +: 2]};
    tick = bcnt_reg == 18'h0;
    stop_done = rx_state_reg == tsq_pkg::RX_STOP && tick
      && !(ctrl_reg[tsq_pkg::STOP2_BIT] && !stop2_reg);
    rx_state_next = rx_state_reg;
    bcnt_next = tick ? baud_reg - 18'h1 : bcnt_reg - 18'h1;
    nbit_next = nbit_reg;
    sh_next = sh_reg;
    par_next = par_reg;
    stop2_next = stop2_reg;
    stb_next = 1'b0;
    char_next = char_reg;
    perr_next = perr_reg;
    ferr_next = ferr_reg;
    case (rx_state_reg)
      tsq_pkg::RX_IDLE: if (prev_reg && !line) begin
        rx_state_next = tsq_pkg::RX_START;
        bcnt_next = {1'b0, baud_reg[17:1]};
      end
      tsq_pkg::RX_START: if (tick) begin
        rx_state_next = line ? tsq_pkg::RX_IDLE : tsq_pkg::RX_DATA;
        {nbit_next, par_next, stop2_next, perr_next, ferr_next} = 7'h0;
      end
      tsq_pkg::RX_DATA: if (tick) begin
        sh_next = {line, sh_reg[7:1]};
        par_next = par_reg ^ line;
        nbit_next = nbit_reg + 3'h1;
        if (nbit_reg == last_bit)
          rx_state_next = pmode == 2'h0 ? tsq_pkg::RX_STOP : tsq_pkg::RX_PAR;
      end
      tsq_pkg::RX_PAR: if (tick) begin
        perr_next = par_reg ^ line ^ (pmode == tsq_pkg::PAR_ODD);
        rx_state_next = tsq_pkg::RX_STOP;
      end
      tsq_pkg::RX_STOP: if (tick) begin
        ferr_next = ferr_reg | ~line;
        stop2_next = 1'b1;
        if (stop_done) begin
          stb_next = 1'b1;
          char_next = sh_reg >> (3'h7 - last_bit);
          rx_state_next = tsq_pkg::RX_IDLE;
        end
      end
      default: rx_state_next = tsq_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= tsq_pkg::RX_IDLE;
      bcnt_reg <= 18'h0;
      nbit_reg <= 3'h0;
      sh_reg <= 8'h00;
      {par_reg, prev_reg, stop2_reg, stb_reg, perr_reg, ferr_reg} <= 6'h0;
      char_reg <= 8'h00;
    end else begin
      rx_state_reg <= rx_state_next;
      bcnt_reg <= bcnt_next;
      nbit_reg <= nbit_next;
      sh_reg <= sh_next;
      {par_reg, prev_reg, stop2_reg, stb_reg, perr_reg, ferr_reg} <=
        {par_next, line, stop2_next, stb_next, perr_next, ferr_next};
      char_reg <= char_next;
    end
  end

  // ==========================================================
  // pattern matcher and sequencer
  logic [4:0] pos_reg [4];
  logic [4:0] pos_next [4];
  logic [3:0] hit_now, first, pev_reg;
  logic [4:0] len;
  logic [47:0] t1_reg, t1_next, t2_reg, t2_next;
  logic [31:0] c1_reg, c1_next, c2_reg, c2_next;
  logic [21:0] sc;
  logic [7:0] ev, evm;
  logic arm, run, ev_ok, tq, cond;
  logic [1:0] tgt_t, tgt_f;

  always_comb begin
    arm = ctrl_reg[tsq_pkg::ARM_BIT];
    pos_next = pos_reg;
    hit_now = 4'h0;
    for (int p = 0; p < tsq_pkg::NPAT; p++) begin
      len = plen_reg[5*p +: 5];
      if (stb_reg && hit_reg == 4'h0 && len != 5'h0) begin
        if (char_reg == pat_reg[6'(p * 16) + 6'(pos_reg[p])]) begin
          pos_next[p] = pos_reg[p] + 5'h1;
          hit_now[p] = pos_next[p] >= len;
        end else begin
          pos_next[p] = {4'h0, char_reg == pat_reg[6'(p * 16)]};
        end
      end
      if (!arm || hit_now[p]) pos_next[p] = 5'h0;
    end
    first = hit_now & (~hit_now + 4'h1);
    hit_next = arm ? hit_reg | first : 4'h0;
    ev = {ext_event, ferr_reg & stb_reg, perr_reg & stb_reg, stb_reg, pev_reg};
    sc = scfg_reg[cur_reg];
    evm = sc[7:0];
    tgt_t = sc[tsq_pkg::NXT_T_LSB +: 2];
    tgt_f = sc[tsq_pkg::NXT_F_LSB +: 2];
    ev_ok = sc[tsq_pkg::AND_BIT] ? &(ev | ~evm) : |(ev & evm);
    case (sc[tsq_pkg::TQ_LSB +: 2])
      2'h1: tq = t1_reg >= t1lim_reg;
      2'h2: tq = t1_reg < t1lim_reg;
      2'h3: tq = t1_reg > t2lim_reg && t1_reg < t1lim_reg;
      default: tq = 1'b1;
    endcase
    cond = ev_ok && tq && (!sc[tsq_pkg::C1Q_BIT] || c1_reg >= c1lim_reg)
      && (!sc[tsq_pkg::C2Q_BIT] || c2_reg >= c2lim_reg);
    run = arm && !trig_reg;
    cur_next = cur_reg;
    trig_next = trig_reg;
    t1_next = t1_reg + 48'h1;
    t2_next = t2_reg + 48'h1;
    c1_next = c1_reg + {31'h0, |pev_reg};
    c2_next = c2_reg + {31'h0, stb_reg};
    if (run && cond) begin
      cur_next = tgt_t;
      trig_next = sc[tsq_pkg::TRIG_BIT];
      if (sc[tsq_pkg::RC1_BIT]) c1_next = 32'h0;
      if (sc[tsq_pkg::RC2_BIT]) c2_next = 32'h0;
      if (sc[tsq_pkg::ST1_BIT]) t1_next = 48'h0;
      if (sc[tsq_pkg::ST2_BIT]) t2_next = 48'h0;
    end else if (run) begin
      cur_next = tgt_f;
    end
    if (!arm) begin
      {cur_next, trig_next} = 3'h0;
      {t1_next, t2_next, c1_next, c2_next} = 160'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 4; p++) pos_reg[p] <= 5'h0;
      hit_reg <= 4'h0;
      pev_reg <= 4'h0;
      cur_reg <= 2'h0;
      trig_reg <= 1'b0;
      trigger_out <= 1'b0;
      {t1_reg, t2_reg, c1_reg, c2_reg} <= 160'h0;
    end else begin
      pos_reg <= pos_next;
      hit_reg <= hit_next;
      pev_reg <= arm ? first : 4'h0;
      cur_reg <= cur_next;
      trig_reg <= trig_next;
      trigger_out <= trig_next;
      {t1_reg, t2_reg, c1_reg, c2_reg} <= {t1_next, t2_next, c1_next, c2_next};
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_last_stop;
    rx_state_reg == tsq_pkg::RX_STOP && stop_done;
  endsequence
  first_only_a: assert property ($rose(|hit_reg) |-> $onehot(hit_reg))
    else $error("more than one pattern latched");
  true_step_a: assert property (run && cond |=> cur_reg == $past(tgt_t))
    else $error("true condition went to wrong state");
  false_step_a: assert property (run && !cond |=> cur_reg == $past(tgt_f))
    else $error("false condition went to wrong state");
  self_hold_a: assert property (
    run && !cond && tgt_f == cur_reg [*2] |-> ##1 $stable(cur_reg))
    else $error("self linked state left while false");
  trig_fire_a: assert property (
    run && cond && sc[tsq_pkg::TRIG_BIT] |=> trigger_out && trig_reg)
    else $error("trigger not raised");
  tmr_restart_a: assert property (
    run && cond && sc[tsq_pkg::ST1_BIT] |=> t1_reg == 48'h0 ##1 t1_reg == 48'h1)
    else $error("timer one not restarted");
  char_report_a: assert property (s_last_stop |=> stb_reg ##1 !stb_reg)
    else $error("character not reported after stop");
  no_parity_a: assert property (
    stb_reg && pmode == 2'h0 && ctrl_reg == $past(ctrl_reg, 2) |-> !perr_reg)
    else $error("parity error without parity");
endmodule
`default_nettype wire

/* verilog/tsq_pkg.sv */
// constants, register map and state codes for the trigger sequencer
// assumes a 25 MHz sample clock and a 32-bit register bus
package tsq_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_MIN = 110;
  localparam int BAUD_MAX = 2_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int DIV_W = 18;
  localparam logic [17:0] DIV_RST = 18'(CLK_HZ / BAUD_DEF);
  // timers span 130 days at 40 ns per tick, so 48 bits
  localparam int TW = 48;
  // ==========================================================
  // register offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] BAUD_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] PLEN_OFS = 12'h00C;
  localparam logic [11:0] C1LIM_OFS = 12'h010;
  localparam logic [11:0] C2LIM_OFS = 12'h014;
  localparam logic [11:0] T1LO_OFS = 12'h018;
  localparam logic [11:0] T1HI_OFS = 12'h01C;
  localparam logic [11:0] T2LO_OFS = 12'h020;
  localparam logic [11:0] T2HI_OFS = 12'h024;
  localparam logic [7:0] SCFG_PAGE = 8'h04;
  localparam logic [3:0] PAT_PAGE = 4'h1;
  // ==========================================================
  // control fields
  localparam int CH_LSB = 0;
  localparam int DB_LSB = 2;
  localparam int PAR_LSB = 4;
  localparam int STOP2_BIT = 6;
  localparam int IDLE_LO_BIT = 7;
  localparam int ARM_BIT = 8;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // state config fields
  localparam int NXT_T_LSB = 9;
  localparam int NXT_F_LSB = 11;
  localparam int AND_BIT = 8;
  localparam int TRIG_BIT = 13;
  localparam int RC1_BIT = 14;
  localparam int RC2_BIT = 15;
  localparam int ST1_BIT = 16;
  localparam int ST2_BIT = 17;
  localparam int TQ_LSB = 18;
  localparam int C1Q_BIT = 20;
  localparam int C2Q_BIT = 21;
  localparam int NSTATE = 4;
  localparam int NPAT = 4;
  localparam int PLEN = 16;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
    RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_t;
endpackage

/* sim/uart_tx_model.sv */
// serial transmitter standing on one observed line of the trigger sequencer
// assumes bit time in aclk cycles and frame format given by the bench
`timescale 1ns/100ps
`default_nettype none
module uart_tx_model (
  input wire logic aclk,
  input wire logic [1:0] nb,
  input wire logic [1:0] par,
  input wire logic stop2,
  input wire logic idle_lo,
  input wire logic [17:0] bit_cyc,
  input wire logic bad_par,
  input wire logic bad_stop,
  output logic line
);
  // ==========================================================
  // frame generation
  logic lvl = 1'b1;
  // line level in idle-high terms, inverted for idle-low lines
  assign line = lvl ^ idle_lo;
  task automatic hold(input logic v);
    lvl <= v;
    repeat (bit_cyc) @(posedge aclk);
  endtask
  task automatic send(input logic [7:0] c);
    logic p;
    p = (par == 2'h2);
    @(posedge aclk);
    hold(1'b0);
    for (int i = 0; i < nb + 5; i++) begin
      hold(c[i]);
      p = p ^ c[i];
    end
    if (par != 2'h0) hold(p ^ bad_par);
    hold(~bad_stop);
    if (stop2) hold(1'b1);
    lvl <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* sim/trigger_sequencer_tb_top.sv */
// self-checking bench for the trigger sequencer: register bus master and scenarios
// assumes uart_tx_model on channels 0 and 2, the other channels held idle
`timescale 1ns/100ps
`default_nettype none
module trigger_sequencer_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ext_event = 1'b0, stop2 = 1'b0, idle_lo = 1'b0;
  logic bad_par = 1'b0, bad_stop = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trigger_out, ln_a, ln_b;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, nb = 2'h3, par = 2'h0;
  logic [17:0] bit_cyc = 18'hC;
  int miscompares = 0, samples_checked = 0;
  always #20 aclk = ~aclk;
  trigger_sequencer trigger_sequencer_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .line_in({~idle_lo, ln_b, ~idle_lo, ln_a}), .ext_event(ext_event),
    .trigger_out(trigger_out));
  uart_tx_model tx_a_i (.aclk(aclk), .nb(nb), .par(par), .stop2(stop2), .idle_lo(idle_lo),
    .bit_cyc(bit_cyc), .bad_par(bad_par), .bad_stop(bad_stop), .line(ln_a));
  uart_tx_model tx_b_i (.aclk(aclk), .nb(nb), .par(par), .stop2(stop2), .idle_lo(idle_lo),
    .bit_cyc(bit_cyc), .bad_par(bad_par), .bad_stop(bad_stop), .line(ln_b));
  // ==========================================================
  // checks, bus cycles and helpers
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t trigger got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic wok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk_word(32'(r), 32'(tsq_pkg::RESP_OK));
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_word(32'(r), 32'(tsq_pkg::RESP_OK));
    chk_word(d & m, e);
  endtask
  task automatic scfg(input logic [1:0] s, input logic [31:0] v);
    wok({tsq_pkg::SCFG_PAGE, s, 2'b00}, v);
  endtask
  task automatic pat(input logic [1:0] p, input logic [3:0] i, input logic [7:0] v);
    wok({tsq_pkg::PAT_PAGE, p, i, 2'b00}, 32'(v));
  endtask
  // disarm first so state, timers, counters and matcher start clean
  task automatic arm(input logic [31:0] c);
    wok(tsq_pkg::CTRL_OFS, c);
    wok(tsq_pkg::CTRL_OFS, c | (32'h1 << tsq_pkg::ARM_BIT));
  endtask
  // the unselected channel carries the inverted character
  task automatic tx(input logic [7:0] c);
    fork
      tx_a_i.send(~c);
      tx_b_i.send(c);
    join
    repeat (4) @(posedge aclk);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk_pin(trigger_out, 1'b0);
    chk_word(32'({awready, wready, arready, bvalid, rvalid}), 32'h1C);
    rchk(tsq_pkg::CTRL_OFS, 32'hFFFFFFFF, 32'h0);
    rchk(tsq_pkg::BAUD_OFS, 32'hFFFFFFFF, 32'(tsq_pkg::DIV_RST));
    rchk(tsq_pkg::STAT_OFS, 32'hFFFFFFFF, 32'h0);
    rd(12'h0F0, d, r);
    chk_word(d, 32'h0);
    chk_word(32'(r), 32'(tsq_pkg::RESP_ERR));
    wr(12'h0F0, 32'h1, r);
    chk_word(32'(r), 32'(tsq_pkg::RESP_ERR));
    wok(tsq_pkg::BAUD_OFS, 32'h377C9);
    rchk(tsq_pkg::BAUD_OFS, 32'hFFFFFFFF, 32'h377C9);
    wok(tsq_pkg::BAUD_OFS, 32'hC);
  endtask
  task automatic t_frames;
    logic [1:0] n, p;
    logic s, il;
    logic [7:0] c;
    logic [31:0] want;
    for (int k = 0; k < 48; k++) begin
      n = 2'(k % 4);
      p = 2'((k / 4) % 3);
      s = ((k / 12) % 2) == 1;
      il = k >= 24;
      c = 8'(k * 53 + 7);
      nb <= n;
      par <= p;
      stop2 <= s;
      idle_lo <= il;
      arm(32'h2 | 32'(n) << 2 | 32'(p) << 4 | 32'(s) << 6 | 32'(il) << 7);
      repeat (k == 24 ? 300 : 2) @(posedge aclk);
      tx(c);
      want = 32'(c & (8'hFF >> (3 - n))) << 8;
      rchk(tsq_pkg::STAT_OFS, 32'h3FF00, want);
    end
    nb <= 2'h3;
    par <= tsq_pkg::PAR_EVEN;
    stop2 <= 1'b0;
    idle_lo <= 1'b0;
    bad_par <= 1'b1;
    arm(32'h1E);
    repeat (300) @(posedge aclk);
    tx(8'h3C);
    rchk(tsq_pkg::STAT_OFS, 32'h30000, 32'h10000);
    bad_par <= 1'b0;
    bad_stop <= 1'b1;
    tx(8'h3D);
    rchk(tsq_pkg::STAT_OFS, 32'h30000, 32'h20000);
    bad_stop <= 1'b0;
    par <= 2'h0;
  endtask
  task automatic t_patterns;
    wok(tsq_pkg::PLEN_OFS, 32'h8003);
    pat(2'h0, 4'h0, 8'h41);
    pat(2'h0, 4'h1, 8'h42);
    pat(2'h0, 4'h2, 8'h43);
    pat(2'h3, 4'h0, 8'h42);
    scfg(2'h0, 32'h200F);
    arm(32'hE);
    tx(8'h41);
    chk_pin(trigger_out, 1'b0);
    tx(8'h42);
    rchk(tsq_pkg::STAT_OFS, 32'h7C, 32'h44);
    chk_pin(trigger_out, 1'b1);
    tx(8'h43);
    rchk(tsq_pkg::STAT_OFS, 32'h78, 32'h40);
    wok(tsq_pkg::PLEN_OFS, 32'h200);
    for (int i = 0; i < 16; i++) pat(2'h1, 4'(i), 8'(8'h30 + i));
    arm(32'hE);
    for (int i = 0; i < 15; i++) tx(8'(8'h30 + i));
    rchk(tsq_pkg::STAT_OFS, 32'h7C, 32'h0);
    tx(8'h3F);
    rchk(tsq_pkg::STAT_OFS, 32'h7C, 32'h14);
  endtask
  task automatic t_flow;
    scfg(2'h0, 32'h280);
    scfg(2'h1, 32'h1C80);
    scfg(2'h2, 32'h1400);
    scfg(2'h3, 32'h3F00);
    arm(32'hE);
    repeat (20) @(posedge aclk);
    rchk(tsq_pkg::STAT_OFS, 32'h7, 32'h0);
    ext_event <= 1'b1;
    @(posedge aclk);
    ext_event <= 1'b0;
    repeat (5) @(posedge aclk);
    rchk(tsq_pkg::STAT_OFS, 32'h7, 32'h7);
  endtask
  task automatic t_timers;
    int spec [3][4];
    spec = '{'{1, 25, 0, 30}, '{2, 25, 1, 5}, '{3, 10, 0, 25}};
    wok(tsq_pkg::T1HI_OFS, 32'hFFFF);
    rchk(tsq_pkg::T1HI_OFS, 32'hFFFFFFFF, 32'hFFFF);
    wok(tsq_pkg::T1HI_OFS, 32'h0);
    wok(tsq_pkg::T1LO_OFS, 32'h28);
    wok(tsq_pkg::T2LO_OFS, 32'h14);
    for (int k = 0; k < 3; k++) begin
      scfg(2'h0, 32'h2100 | 32'(spec[k][0]) << tsq_pkg::TQ_LSB);
      arm(32'hE);
      repeat (spec[k][1]) @(posedge aclk);
      chk_pin(trigger_out, spec[k][2] == 1);
      repeat (spec[k][3]) @(posedge aclk);
      chk_pin(trigger_out, 1'b1);
    end
  endtask
  task automatic t_restart_count;
    wok(tsq_pkg::T1LO_OFS, 32'h3C);
    scfg(2'h0, 32'h10210);
    scfg(2'h1, 32'h42B00);
    arm(32'hE);
    repeat (100) @(posedge aclk);
    tx(8'h11);
    chk_pin(trigger_out, 1'b0);
    repeat (70) @(posedge aclk);
    chk_pin(trigger_out, 1'b1);
    wok(tsq_pkg::C2LIM_OFS, 32'h2);
    scfg(2'h0, 32'h202100);
    arm(32'hE);
    tx(8'h22);
    chk_pin(trigger_out, 1'b0);
    tx(8'h23);
    chk_pin(trigger_out, 1'b1);
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    wrap_up;
  end
  initial begin
    do_reset;
    t_reset;
    t_frames;
    t_patterns;
    t_flow;
    t_timers;
    t_restart_count;
    do_reset;
    t_reset;
    wrap_up;
  end
endmodule
`default_nettype wire
